// File: core/ddc_pkg.sv
package ddc_pkg;

  localparam int ADC_W    = 12;
  localparam int DATA_W   = 20;
  localparam int ADDR_W   = 8;
  localparam int IQ_W     = 16;
  localparam int SCALE_W  = 5;
  localparam int DLY_W    = 4;
  localparam int DLY_N    = 16;
  localparam int LAT_W    = 20;

  // Channel register offsets
  localparam logic [7:0] OFF_HOLDOFF     = 8'h84;
  localparam logic [7:0] OFF_FREQ_A      = 8'h85;
  localparam logic [7:0] OFF_FREQ_B      = 8'h86;
  localparam logic [7:0] OFF_PHASE       = 8'h87;
  localparam logic [7:0] OFF_CTRL        = 8'h88;
  localparam logic [7:0] OFF_SCALE       = 8'h92;
  localparam logic [7:0] OFF_UPPER_A     = 8'h94;
  localparam logic [7:0] OFF_LOWER_A     = 8'h95;
  localparam logic [7:0] OFF_UPPER_B     = 8'h96;
  localparam logic [7:0] OFF_LOWER_B     = 8'h97;
  localparam logic [7:0] OFF_DWELL_A     = 8'h98;
  localparam logic [7:0] OFF_DWELL_B     = 8'h99;
  localparam logic [7:0] OFF_GAIN_DELAY  = 8'h9a;
  // External map
  localparam logic [2:0] EXT_OFF_SYNC_EN = 3'h4;

  // Control bits
  localparam int CTRL_BYPASS  = 0;
  localparam int CTRL_PDITH   = 1;
  localparam int CTRL_ADITH   = 2;
  localparam int CTRL_CLRACC  = 3;
  localparam int CTRL_RSV_LO  = 4;
  localparam int CTRL_RSV_HI  = 5;
  localparam int CTRL_INSEL   = 6;
  localparam int CTRL_SYNC_LO = 7;
  localparam int CTRL_SYNC_HI = 8;
  localparam int CTRL_W       = 9;

  // Scale pair fields
  localparam int SCALE_LOUD_LO  = 0;
  localparam int SCALE_LOUD_HI  = 4;
  localparam int SCALE_QUIET_LO = 5;
  localparam int SCALE_QUIET_HI = 9;
  localparam int SCALE_PAIR_W   = 10;

  // Latency terms
  localparam logic [LAT_W-1:0] LAT_FIFTH_ORDER_COMB_FILTER_ADD = 20'h0_0007;
  localparam logic [LAT_W-1:0] LAT_FIXED    = 20'h0_001a;

  // Oscillator
  localparam logic [5:0]  PHASE_QUARTER = 6'h10;
  localparam logic [15:0] LFSR_SEED     = 16'hace1;
  localparam logic [15:0] LFSR_TAPS     = 16'hb400;
  localparam logic [14:0] SINE_TBL [16] = '{
    15'h0648, 15'h12c8, 15'h1f1a, 15'h2b1f, 15'h36ba, 15'h41ce, 15'h4c40, 15'h55f5,
    15'h5ed7, 15'h66cf, 15'h6dc9, 15'h73b5, 15'h7884, 15'h7c29, 15'h7e9c, 15'h7fd8};

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ddc_reg_req_s;

  typedef struct packed {
    logic signed [IQ_W-1:0] i;
    logic signed [IQ_W-1:0] q;
  } ddc_iq_s;

  typedef enum logic {HO_IDLE, HO_COUNT} ddc_holdoff_e;

endpackage : ddc_pkg

// File: core/ddc_gain_switch_and_nco_tuner.sv
`timescale 1ns/1ns
module ddc_gain_switch_and_nco_tuner (
  // Clock and reset
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_sys_rst,
  input  wire logic                              i_clk_en,
  // Converter samples
  input  wire logic signed [ddc_pkg::ADC_W-1:0]  i_adc_a,
  input  wire logic signed [ddc_pkg::ADC_W-1:0]  i_adc_b,
  // Channel register port
  input  wire ddc_pkg::ddc_reg_req_s             i_reg_req,
  output logic [ddc_pkg::DATA_W-1:0]             o_reg_rdata,
  // External map port
  input  wire logic                              i_ext_wr,
  input  wire logic [2:0]                        i_ext_addr,
  input  wire logic [7:0]                        i_ext_wdata,
  output logic [7:0]                             o_ext_rdata,
  // Sync and sleep
  input  wire logic [3:0]                        i_sync_pins,
  input  wire logic                              i_chan_sleep,
  // Filter settings for latency
  input  wire logic [11:0]                       i_resampling_comb_filter_decim,
  input  wire logic [5:0]                        i_fifth_order_comb_filter_decim,
  input  wire logic [7:0]                        i_fir_taps,
  output logic [ddc_pkg::LAT_W-1:0]              o_path_latency,
  // Attenuator flags
  output logic                                   o_gain_switch_flag_port_a,
  output logic                                   o_gain_switch_flag_port_b,
  // Data to resampling comb filter
  output ddc_pkg::ddc_iq_s                       o_iq,
  output logic                                   o_iq_valid
);

  // Register fields
  logic [15:0]                     holdoff_cfg;
  logic [31:0]                     freq_shadow;
  logic [31:0]                     freq_active;
  logic [15:0]                     phase_off;
  logic [ddc_pkg::CTRL_W-1:0]      ctrl;
  logic [ddc_pkg::SCALE_PAIR_W-1:0] scale_pair;
  logic [ddc_pkg::ADC_W-1:0]       upper_th [2];
  logic [ddc_pkg::ADC_W-1:0]       lower_th [2];
  logic [15:0]                     dwell_cfg [2];
  logic [ddc_pkg::DLY_W-1:0]       gain_delay;
  logic [7:0]                      sync_en;

  // Gain switch state
  logic [1:0]                      flag;
  logic [1:0]                      dwell_run;
  logic [15:0]                     dwell_cnt [2];
  logic [ddc_pkg::ADC_W-1:0]       mag [2];
  logic signed [ddc_pkg::ADC_W-1:0] smp [2];

  // Scale timing
  logic [ddc_pkg::DLY_N-1:0]       flag_hist;
  logic                            flag_dly;
  logic [ddc_pkg::SCALE_W-1:0]     scale_sel;

  // Frequency hold-off
  ddc_pkg::ddc_holdoff_e           ho_state;
  logic [15:0]                     ho_cnt;
  logic                            sleep_q;
  logic                            sync_q;
  logic                            sync_sel;
  logic                            wake;
  logic                            hop;
  logic                            load_now;

  // Oscillator and mixer
  logic [31:0]                     phase_acc;
  logic [15:0]                     lfsr;
  logic [15:0]                     phase_sum;
  logic [5:0]                      phase_idx;
  logic signed [15:0]              sin_v;
  logic signed [15:0]              cos_v;
  logic signed [ddc_pkg::ADC_W-1:0] x_sel;
  logic signed [27:0]              prod_i;
  logic signed [27:0]              prod_q;
  logic signed [ddc_pkg::IQ_W-1:0] mix_i;
  logic signed [ddc_pkg::IQ_W-1:0] mix_q;
  logic                            mix_vld;

  // Sample ports
  assign smp[0] = i_adc_a;
  assign smp[1] = i_adc_b;

  // Register writes
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      holdoff_cfg <= 16'h0000;
      freq_shadow <= 32'h0000_0000;
      phase_off   <= 16'h0000;
      ctrl        <= 9'h000;
      scale_pair  <= 10'h000;
      upper_th    <= '{12'hfff, 12'hfff};
      lower_th    <= '{12'h000, 12'h000};
      dwell_cfg   <= '{16'h0000, 16'h0000};
      gain_delay  <= 4'h0;
    end else if (i_clk_en && i_reg_req.wr) begin
      unique case (i_reg_req.addr)
        ddc_pkg::OFF_HOLDOFF:    holdoff_cfg <= i_reg_req.wdata[15:0];
        ddc_pkg::OFF_FREQ_A:     freq_shadow[15:0] <= i_reg_req.wdata[15:0];
        ddc_pkg::OFF_FREQ_B:     freq_shadow[31:16] <= i_reg_req.wdata[15:0];
        ddc_pkg::OFF_PHASE:      phase_off <= i_reg_req.wdata[15:0];
        ddc_pkg::OFF_CTRL:       ctrl <= i_reg_req.wdata[ddc_pkg::CTRL_W-1:0];
        ddc_pkg::OFF_SCALE:      scale_pair <= i_reg_req.wdata[ddc_pkg::SCALE_PAIR_W-1:0];
        ddc_pkg::OFF_UPPER_A:    upper_th[0] <= i_reg_req.wdata[ddc_pkg::ADC_W-1:0];
        ddc_pkg::OFF_LOWER_A:    lower_th[0] <= i_reg_req.wdata[ddc_pkg::ADC_W-1:0];
        ddc_pkg::OFF_UPPER_B:    upper_th[1] <= i_reg_req.wdata[ddc_pkg::ADC_W-1:0];
        ddc_pkg::OFF_LOWER_B:    lower_th[1] <= i_reg_req.wdata[ddc_pkg::ADC_W-1:0];
        ddc_pkg::OFF_DWELL_A:    dwell_cfg[0] <= i_reg_req.wdata[15:0];
        ddc_pkg::OFF_DWELL_B:    dwell_cfg[1] <= i_reg_req.wdata[15:0];
        ddc_pkg::OFF_GAIN_DELAY: gain_delay <= i_reg_req.wdata[ddc_pkg::DLY_W-1:0];
        default: ;
      endcase
    end
  end

  // Register reads
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 20'h0_0000;
    end else if (i_clk_en && i_reg_req.rd) begin
      unique case (i_reg_req.addr)
        ddc_pkg::OFF_HOLDOFF:    o_reg_rdata <= {4'h0, holdoff_cfg};
        ddc_pkg::OFF_FREQ_A:     o_reg_rdata <= {4'h0, freq_active[15:0]};
        ddc_pkg::OFF_FREQ_B:     o_reg_rdata <= {4'h0, freq_active[31:16]};
        ddc_pkg::OFF_PHASE:      o_reg_rdata <= {4'h0, phase_off};
        ddc_pkg::OFF_CTRL:       o_reg_rdata <= {11'h000, ctrl[8:6], 2'b00, ctrl[3:0]};
        ddc_pkg::OFF_SCALE:      o_reg_rdata <= {10'h000, scale_pair};
        ddc_pkg::OFF_UPPER_A:    o_reg_rdata <= {8'h00, upper_th[0]};
        ddc_pkg::OFF_LOWER_A:    o_reg_rdata <= {8'h00, lower_th[0]};
        ddc_pkg::OFF_UPPER_B:    o_reg_rdata <= {8'h00, upper_th[1]};
        ddc_pkg::OFF_LOWER_B:    o_reg_rdata <= {8'h00, lower_th[1]};
        ddc_pkg::OFF_DWELL_A:    o_reg_rdata <= {4'h0, dwell_cfg[0]};
        ddc_pkg::OFF_DWELL_B:    o_reg_rdata <= {4'h0, dwell_cfg[1]};
        ddc_pkg::OFF_GAIN_DELAY: o_reg_rdata <= {16'h0000, gain_delay};
        default:                 o_reg_rdata <= 20'h0_0000;
      endcase
    end
  end

  // External sync enable register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sync_en <= 8'h00;
    end else if (i_clk_en && i_ext_wr && i_ext_addr == ddc_pkg::EXT_OFF_SYNC_EN) begin
      sync_en <= i_ext_wdata;
    end
  end

  // External read back
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_ext_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_ext_rdata <= (i_ext_addr == ddc_pkg::EXT_OFF_SYNC_EN) ? sync_en : 8'h00;
    end
  end

  localparam int LAT_W = ddc_pkg::LAT_W;

  // Path latency
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_path_latency <= 20'h0_0000;
    end else if (i_clk_en) begin
      o_path_latency <= LAT_W'(20'(i_resampling_comb_filter_decim) * (20'(i_fifth_order_comb_filter_decim) + ddc_pkg::LAT_FIFTH_ORDER_COMB_FILTER_ADD))
                        + 20'(i_fir_taps) + ddc_pkg::LAT_FIXED;
    end
  end

  // Gain switching per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    // Sample magnitude
    assign mag[p] = smp[p][ddc_pkg::ADC_W-1] ? 12'(-smp[p]) : 12'(smp[p]);

    always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
        flag[p]      <= 1'b0;
        dwell_run[p] <= 1'b0;
        dwell_cnt[p] <= 16'h0000;
      end else if (i_clk_en) begin
        if (mag[p] >= upper_th[p]) begin
          flag[p]      <= 1'b1;
          dwell_run[p] <= 1'b0;
          dwell_cnt[p] <= 16'h0000;
        end else if (flag[p]) begin
          if (mag[p] < lower_th[p]) begin
            if (!dwell_run[p]) begin
              if (dwell_cfg[p] == 16'h0000) begin
                flag[p] <= 1'b0;
              end else begin
                dwell_cnt[p] <= dwell_cfg[p];
                dwell_run[p] <= 1'b1;
              end
            end else if (dwell_cnt[p] == 16'h0001) begin
              dwell_cnt[p] <= 16'h0000;
              dwell_run[p] <= 1'b0;
              flag[p]      <= 1'b0;
            end else begin
              dwell_cnt[p] <= dwell_cnt[p] - 16'h0001;
            end
          end else begin
            dwell_run[p] <= 1'b0;
            dwell_cnt[p] <= 16'h0000;
          end
        end
      end
    end
  end

  // Attenuator flags
  assign o_gain_switch_flag_port_a = flag[0];
  assign o_gain_switch_flag_port_b = flag[1];

  // Delay of the monitored flag
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      flag_hist <= 16'h0000;
    end else if (i_clk_en) begin
      flag_hist <= {flag_hist[ddc_pkg::DLY_N-2:0], flag[ctrl[ddc_pkg::CTRL_INSEL]]};
    end
  end

  // Scale selection
  assign flag_dly  = (gain_delay == 4'h0) ? flag[ctrl[ddc_pkg::CTRL_INSEL]]
                                          : flag_hist[gain_delay - 4'h1];
  assign scale_sel = flag_dly ? scale_pair[ddc_pkg::SCALE_LOUD_HI:ddc_pkg::SCALE_LOUD_LO]
                              : scale_pair[ddc_pkg::SCALE_QUIET_HI:ddc_pkg::SCALE_QUIET_LO];

  // Wake and hop detection
  assign sync_sel = i_sync_pins[ctrl[ddc_pkg::CTRL_SYNC_HI:ddc_pkg::CTRL_SYNC_LO]]
                    & sync_en[ctrl[ddc_pkg::CTRL_SYNC_HI:ddc_pkg::CTRL_SYNC_LO]];
  assign wake     = sleep_q & ~i_chan_sleep;
  assign hop      = sync_sel & ~sync_q;
  assign load_now = (ho_state == ddc_pkg::HO_COUNT) && (ho_cnt == 16'h0001);

  // Sleep history
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sleep_q <= 1'b1;
    end else if (i_clk_en) begin
      sleep_q <= i_chan_sleep;
    end
  end

  // Sync pin history
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sync_q <= 1'b0;
    end else if (i_clk_en) begin
      sync_q <= sync_sel;
    end
  end

  // Hold-off counter
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ho_state <= ddc_pkg::HO_IDLE;
      ho_cnt   <= 16'h0000;
    end else if (i_clk_en) begin
      if ((wake || hop) && holdoff_cfg != 16'h0000) begin
        ho_state <= ddc_pkg::HO_COUNT;
        ho_cnt   <= holdoff_cfg;
      end else begin
        unique case (ho_state)
          ddc_pkg::HO_IDLE:  ho_cnt <= ho_cnt;
          ddc_pkg::HO_COUNT: begin
            if (ho_cnt == 16'h0001) begin
              ho_state <= ddc_pkg::HO_IDLE;
            end
            ho_cnt <= ho_cnt - 16'h0001;
          end
        endcase
      end
    end
  end

  // Active frequency from shadow
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      freq_active <= 32'h0000_0000;
    end else if (i_clk_en && load_now) begin
      freq_active <= freq_shadow;
    end
  end

  // Phase accumulator, cleared on load when CTRL_CLRACC is set
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      phase_acc <= 32'h0000_0000;
    end else if (i_clk_en) begin
      if (load_now && ctrl[ddc_pkg::CTRL_CLRACC]) begin
        phase_acc <= 32'h0000_0000;
      end else if (!i_chan_sleep) begin
        phase_acc <= phase_acc + freq_active;
      end
    end
  end

  // Dither sequence
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      lfsr <= ddc_pkg::LFSR_SEED;
    end else if (i_clk_en) begin
      lfsr <= lfsr[0] ? ((lfsr >> 1) ^ ddc_pkg::LFSR_TAPS) : (lfsr >> 1);
    end
  end

  // Phase index
  assign phase_sum = phase_acc[31:16] + phase_off
                     + (ctrl[ddc_pkg::CTRL_PDITH] ? {6'h00, lfsr[9:0]} : 16'h0000);
  assign phase_idx = phase_sum[15:10];

  function automatic logic signed [15:0] ddc_sine(input logic [5:0] p, input logic dith);
    logic [3:0]  ix;
    logic [15:0] m;
    ix = p[4] ? ~p[3:0] : p[3:0];
    m  = {1'b0, ddc_pkg::SINE_TBL[ix]} + {15'h0000, dith};
    return p[5] ? -$signed(m) : $signed(m);
  endfunction : ddc_sine

  // Quadrature lookup and input select
  assign sin_v  = ddc_sine(phase_idx, ctrl[ddc_pkg::CTRL_ADITH] & lfsr[15]);
  assign cos_v  = ddc_sine(6'(phase_idx + ddc_pkg::PHASE_QUARTER), ctrl[ddc_pkg::CTRL_ADITH] & lfsr[14]);
  assign x_sel  = ctrl[ddc_pkg::CTRL_INSEL] ? i_adc_b : i_adc_a;
  assign prod_i = x_sel * cos_v;
  assign prod_q = -(x_sel * sin_v);

  // Mixer valid
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mix_vld <= 1'b0;
    end else if (i_clk_en) begin
      mix_vld <= 1'b1;
    end
  end

  // Mixer stage
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mix_i <= 16'h0000;
      mix_q <= 16'h0000;
    end else if (i_clk_en) begin
      if (ctrl[ddc_pkg::CTRL_BYPASS]) begin
        mix_i <= {i_adc_a, 4'h0};
        mix_q <= {i_adc_b, 4'h0};
      end else begin
        mix_i <= prod_i[26:11];
        mix_q <= prod_q[26:11];
      end
    end
  end

  // Scaling ahead of the resampler
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_iq <= '0;
    end else if (i_clk_en) begin
      o_iq.i <= mix_i >>> scale_sel;
      o_iq.q <= mix_q >>> scale_sel;
    end
  end

  // Output valid, low while frozen
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_iq_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_iq_valid <= mix_vld;
    end else begin
      o_iq_valid <= 1'b0;
    end
  end

endmodule : ddc_gain_switch_and_nco_tuner

// File: tb/ddc_gain_chk.sv
`timescale 1ns/1ns
module ddc_gain_chk (
  // Clock and control
  input wire logic                             i_sys_clk,
  input wire logic                             i_sys_rst,
  input wire logic                             i_clk_en,
  // Samples and registers
  input wire logic signed [ddc_pkg::ADC_W-1:0] i_adc_a,
  input wire logic signed [ddc_pkg::ADC_W-1:0] i_adc_b,
  input wire ddc_pkg::ddc_reg_req_s            i_reg_req,
  input wire logic [ddc_pkg::DATA_W-1:0]       o_reg_rdata,
  // Latency and flags
  input wire logic [11:0]                      i_resampling_comb_filter_decim,
  input wire logic [5:0]                       i_fifth_order_comb_filter_decim,
  input wire logic [7:0]                       i_fir_taps,
  input wire logic [ddc_pkg::LAT_W-1:0]        o_path_latency,
  input wire logic                             o_gain_switch_flag_port_a,
  input wire logic                             o_gain_switch_flag_port_b
);
  logic [11:0] up_a, lo_a, up_b, lo_b, mag_a, mag_b;
  logic [15:0] dw_a, dw_b;
  logic [16:0] run_a, run_b;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  assign mag_a = i_adc_a[11] ? 12'(-i_adc_a) : 12'(i_adc_a);
  assign mag_b = i_adc_b[11] ? 12'(-i_adc_b) : 12'(i_adc_b);
  // Threshold and dwell copies
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      up_a <= 12'hfff;
      up_b <= 12'hfff;
      lo_a <= 12'h000;
      lo_b <= 12'h000;
      dw_a <= 16'h0000;
      dw_b <= 16'h0000;
    end else if (i_clk_en && i_reg_req.wr) begin
      case (i_reg_req.addr)
        ddc_pkg::OFF_UPPER_A: up_a <= i_reg_req.wdata[11:0];
        ddc_pkg::OFF_LOWER_A: lo_a <= i_reg_req.wdata[11:0];
        ddc_pkg::OFF_UPPER_B: up_b <= i_reg_req.wdata[11:0];
        ddc_pkg::OFF_LOWER_B: lo_b <= i_reg_req.wdata[11:0];
        ddc_pkg::OFF_DWELL_A: dw_a <= i_reg_req.wdata[15:0];
        ddc_pkg::OFF_DWELL_B: dw_b <= i_reg_req.wdata[15:0];
        default: ;
      endcase
    end
  end
  // Run of below-lower samples while flagged
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      run_a <= '0;
      run_b <= '0;
    end else if (i_clk_en) begin
      run_a <= (o_gain_switch_flag_port_a && mag_a < lo_a) ? run_a + 17'h0_0001 : '0;
      run_b <= (o_gain_switch_flag_port_b && mag_b < lo_b) ? run_b + 17'h0_0001 : '0;
    end
  end
  latency_calc_a : assert property (
    !$past(i_sys_rst) && $past(i_clk_en) |-> o_path_latency == $past(i_resampling_comb_filter_decim)
      * ($past(i_fifth_order_comb_filter_decim) + ddc_pkg::LAT_FIFTH_ORDER_COMB_FILTER_ADD) + $past(i_fir_taps) + ddc_pkg::LAT_FIXED)
    else $error("path latency mismatch");
  flag_set_a : assert property (
    i_clk_en && mag_a >= up_a |=> o_gain_switch_flag_port_a)
    else $error("port a flag not set");
  port_b_set_a : assert property (
    i_clk_en && mag_b >= up_b |=> o_gain_switch_flag_port_b)
    else $error("port b flag not set");
  flag_hold_a : assert property (
    o_gain_switch_flag_port_a && !(i_clk_en && mag_a < lo_a) |=> o_gain_switch_flag_port_a)
    else $error("port a flag dropped early");
  drop_count_a : assert property (
    !$past(i_sys_rst) && $fell(o_gain_switch_flag_port_a) |-> run_a == 17'(dw_a) + 17'h0_0001)
    else $error("port a dwell count wrong");
  drop_bound_a : assert property (
    run_a > 17'(dw_a) |-> !o_gain_switch_flag_port_a)
    else $error("port a flag held too long");
  port_b_drop_a : assert property (
    !$past(i_sys_rst) && $fell(o_gain_switch_flag_port_b) |-> run_b == 17'(dw_b) + 17'h0_0001)
    else $error("port b dwell count wrong");
  ctrl_rsv_a : assert property (
    i_clk_en && i_reg_req.rd && i_reg_req.addr == ddc_pkg::OFF_CTRL |=> o_reg_rdata[5:4] == 2'b00)
    else $error("reserved control bits read nonzero");
endmodule : ddc_gain_chk

bind ddc_gain_switch_and_nco_tuner ddc_gain_chk chk_u (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_adc_a(i_adc_a), .i_adc_b(i_adc_b), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
  .i_resampling_comb_filter_decim(i_resampling_comb_filter_decim), .i_fifth_order_comb_filter_decim(i_fifth_order_comb_filter_decim), .i_fir_taps(i_fir_taps),
  .o_path_latency(o_path_latency), .o_gain_switch_flag_port_a(o_gain_switch_flag_port_a),
  .o_gain_switch_flag_port_b(o_gain_switch_flag_port_b)
);

// File: tb/ddc_adc_model.sv
`timescale 1ns/1ns
module ddc_adc_model (
  // Clock and levels
  input  wire logic                      i_sys_clk,
  input  wire logic [ddc_pkg::ADC_W-1:0] i_lvl_a,
  input  wire logic [ddc_pkg::ADC_W-1:0] i_lvl_b,
  // Attenuator flags
  input  wire logic                      i_atten_a,
  input  wire logic                      i_atten_b,
  // Samples and attenuator state
  output logic [ddc_pkg::ADC_W-1:0]      o_adc_a,
  output logic [ddc_pkg::ADC_W-1:0]      o_adc_b,
  output logic [1:0]                     o_atten_on
);
  // One converted sample per clock
  always_ff @(posedge i_sys_clk) begin
    o_adc_a <= i_lvl_a;
    o_adc_b <= i_lvl_b;
  end
  // Attenuator follows the flags
  always_ff @(posedge i_sys_clk) begin
    o_atten_on <= {i_atten_b, i_atten_a};
  end
endmodule : ddc_adc_model

// File: tb/ddc_gain_switch_and_nco_tuner_tb.sv
`timescale 1ns/1ns
module ddc_gain_switch_and_nco_tuner_tb;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  clk_en = 1'b1;
  logic [11:0]           lvl_a = '0, lvl_b = '0, adc_a, adc_b;
  ddc_pkg::ddc_reg_req_s req = '0;
  logic [19:0]           rdata, lat;
  logic                  ext_wr = 1'b0, sleep = 1'b0, flag_a, flag_b, iq_valid;
  logic [2:0]            ext_addr = 3'h0;
  logic [7:0]            ext_wdata = 8'h00, ext_rdata, taps = 8'h01;
  logic [3:0]            sync = 4'h0;
  logic [11:0]           resampling_comb_filter = 12'h001;
  logic [5:0]            fifth_order_comb_filter = 6'h01;
  ddc_pkg::ddc_iq_s      iq;
  int                    n_fail = 0, n_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  ddc_gain_switch_and_nco_tuner dut_u (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_adc_a(adc_a), .i_adc_b(adc_b),
    .i_reg_req(req), .o_reg_rdata(rdata), .i_ext_wr(ext_wr), .i_ext_addr(ext_addr),
    .i_ext_wdata(ext_wdata), .o_ext_rdata(ext_rdata), .i_sync_pins(sync), .i_chan_sleep(sleep),
    .i_resampling_comb_filter_decim(resampling_comb_filter), .i_fifth_order_comb_filter_decim(fifth_order_comb_filter), .i_fir_taps(taps), .o_path_latency(lat),
    .o_gain_switch_flag_port_a(flag_a), .o_gain_switch_flag_port_b(flag_b),
    .o_iq(iq), .o_iq_valid(iq_valid));
  ddc_adc_model adc_u (.i_sys_clk(clk), .i_lvl_a(lvl_a), .i_lvl_b(lvl_b), .i_atten_a(flag_a),
    .i_atten_b(flag_b), .o_adc_a(adc_a), .o_adc_b(adc_b), .o_atten_on());
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n
  task automatic wr(input logic [7:0] a, input logic [19:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [19:0] e, input string what);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 20'h0_0000};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(what, {12'h000, e}, {12'h000, rdata});
  endtask : rd_chk
  task automatic set_lvl(input logic [11:0] a, input logic [11:0] b);
    @(posedge clk);
    lvl_a <= a;
    lvl_b <= b;
  endtask : set_lvl
  task automatic hop(input logic [3:0] p);
    @(posedge clk);
    sync <= p;
    @(posedge clk);
    sync <= 4'h0;
  endtask : hop
  task automatic t_regs();
    rd_chk(ddc_pkg::OFF_UPPER_A, 20'h0_0fff, "upper reset");
    wr(ddc_pkg::OFF_CTRL, 20'h0_01cf);
    rd_chk(ddc_pkg::OFF_CTRL, 20'h0_01cf, "ctrl");
    wr(ddc_pkg::OFF_SCALE, 20'h0_0fff);
    rd_chk(ddc_pkg::OFF_SCALE, 20'h0_03ff, "scale pair");
    rd_chk(8'h00, 20'h0_0000, "unmapped");
    wr(ddc_pkg::OFF_CTRL, 20'h0_0000);
  endtask : t_regs
  task automatic t_latency();
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      resampling_comb_filter <= k ? 12'hfff : 12'h004;
      fifth_order_comb_filter <= k ? 6'h3f : 6'h02;
      taps <= k ? 8'hff : 8'h10;
      wait_n(2);
      chk("latency", 32'(20'(resampling_comb_filter) * (20'(fifth_order_comb_filter) + 20'h0_0007) + 20'(taps) + 20'h0_001a), 32'(lat));
    end
  endtask : t_latency
  task automatic t_dwell();
    wr(ddc_pkg::OFF_UPPER_A, 20'h0_0400);
    wr(ddc_pkg::OFF_LOWER_A, 20'h0_0100);
    wr(ddc_pkg::OFF_DWELL_A, 20'h0_0003);
    set_lvl(12'hc00, 12'h000);
    wait_n(3);
    chk("flag a set", 32'h1, 32'(flag_a));
    set_lvl(12'h200, 12'h000);
    wait_n(8);
    chk("flag a between", 32'h1, 32'(flag_a));
    chk("flag b", 32'h0, 32'(flag_b));
    set_lvl(12'h050, 12'h000);
    wait_n(2);
    set_lvl(12'h200, 12'h000);
    wait_n(4);
    chk("flag a rearmed", 32'h1, 32'(flag_a));
    set_lvl(12'h050, 12'h000);
    wait_n(4);
    chk("flag a dwell", 32'h1, 32'(flag_a));
    wait_n(1);
    chk("flag a drop", 32'h0, 32'(flag_a));
  endtask : t_dwell
  task automatic t_scale();
    wr(ddc_pkg::OFF_UPPER_B, 20'h0_0400);
    wr(ddc_pkg::OFF_LOWER_B, 20'h0_0100);
    wr(ddc_pkg::OFF_SCALE, 20'h0_0041);
    wr(ddc_pkg::OFF_CTRL, 20'h0_0001);
    set_lvl(12'h500, 12'hf80);
    wait_n(6);
    chk("iq loud a", 32'h2800_fc00, iq);
    chk("iq valid", 32'h1, 32'(iq_valid));
    wr(ddc_pkg::OFF_CTRL, 20'h0_0041);
    wait_n(4);
    chk("iq quiet b", 32'h1400_fe00, iq);
    set_lvl(12'h500, 12'hb00);
    wait_n(6);
    chk("iq loud b", 32'h2800_d800, iq);
    wr(ddc_pkg::OFF_GAIN_DELAY, 20'h0_0003);
    set_lvl(12'h500, 12'hf80);
    wait_n(4);
    chk("iq delayed loud", 32'h2800_fc00, iq);
    wait_n(2);
    chk("iq delayed quiet", 32'h1400_fe00, iq);
    @(posedge clk);
    clk_en <= 1'b0;
    lvl_a  <= 12'h000;
    wait_n(8);
    chk("flag a frozen", 32'h1, 32'(flag_a));
    chk("valid frozen", 32'h0, 32'(iq_valid));
    @(posedge clk);
    clk_en <= 1'b1;
    wr(ddc_pkg::OFF_CTRL, 20'h0_0000);
    set_lvl(12'h000, 12'h000);
  endtask : t_scale
  task automatic t_freq();
    @(posedge clk);
    ext_wr <= 1'b1;
    ext_addr <= ddc_pkg::EXT_OFF_SYNC_EN;
    ext_wdata <= 8'h08;
    @(posedge clk);
    ext_wr <= 1'b0;
    wait_n(1);
    chk("sync enables", 32'h0000_0008, 32'(ext_rdata));
    wr(ddc_pkg::OFF_CTRL, 20'h0_0180);
    wr(ddc_pkg::OFF_FREQ_A, 20'h0_1234);
    wr(ddc_pkg::OFF_FREQ_B, 20'h0_5678);
    rd_chk(ddc_pkg::OFF_FREQ_A, 20'h0_0000, "shadow hidden");
    hop(4'h8);
    wait_n(4);
    rd_chk(ddc_pkg::OFF_FREQ_A, 20'h0_0000, "holdoff zero");
    wr(ddc_pkg::OFF_HOLDOFF, 20'h0_0008);
    hop(4'h1);
    wait_n(12);
    rd_chk(ddc_pkg::OFF_FREQ_A, 20'h0_0000, "other pin");
    hop(4'h8);
    rd_chk(ddc_pkg::OFF_FREQ_B, 20'h0_0000, "holdoff running");
    wait_n(10);
    rd_chk(ddc_pkg::OFF_FREQ_B, 20'h0_5678, "freq high");
    rd_chk(ddc_pkg::OFF_FREQ_A, 20'h0_1234, "freq low");
    wr(ddc_pkg::OFF_FREQ_A, 20'h0_0abc);
    wr(ddc_pkg::OFF_HOLDOFF, 20'h0_0001);
    @(posedge clk);
    sleep <= 1'b1;
    repeat (2) @(posedge clk);
    sleep <= 1'b0;
    wait_n(4);
    rd_chk(ddc_pkg::OFF_FREQ_A, 20'h0_0abc, "wake update");
  endtask : t_freq
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_latency();
    t_dwell();
    t_scale();
    t_freq();
    conclude();
  end
endmodule : ddc_gain_switch_and_nco_tuner_tb
